// ### dv/weld_link_properties.sv
`default_nettype none
module weld_link_properties #(
  parameter int unsigned HB_HALF_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] mode,
  input wire logic [1:0] line,
  input wire logic [1:0] dual,
  input wire logic [15:0] status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic hb_prev_q;
  logic hb_seen_q;
  logic [31:0] hb_cnt_q;
  // cycles since the last heartbeat edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hb_prev_q <= 1'b0;
      hb_seen_q <= 1'b0;
      hb_cnt_q <= 32'h0;
    end
    else
    begin
      hb_prev_q <= status[0];
      hb_seen_q <= hb_seen_q | (status[0] != hb_prev_q);
      hb_cnt_q <= (status[0] != hb_prev_q) ? 32'h0 : hb_cnt_q + 32'h1;
    end
  end
  sequence released;
    $fell(rst_i);
  endsequence
  sequence hb_rises;
    ##[1:20] status[0];
  endsequence
  // robot never sends reserved or undefined codes
  chk_line_legal: assert property (line != 2'h3)
    else $error("reserved line sent");
  chk_dual_legal: assert property (dual != 2'h3)
    else $error("reserved dual mode sent");
  chk_mode_legal: assert property (mode inside {5'h00, 5'h01, 5'h02, 5'h08,
    5'h09, 5'h18, 5'h19}) else $error("undefined mode sent");
  chk_spare_bit_low: assert property (status[11] == 1'b0)
    else $error("unused status bit set");
  chk_status_reset: assert property (released |-> status == 16'h2100)
    else $error("status reset value wrong");
  chk_ctrl_reset: assert property (released |-> mode == 5'h00 && line == 2'h0
    && dual == 2'h0) else $error("control reset value wrong");
  chk_hb_starts: assert property (released |-> hb_rises)
    else $error("heartbeat never toggled");
  chk_hb_period: assert property (hb_seen_q && status[0] != hb_prev_q
    |-> hb_cnt_q == HB_HALF_CYCLES - 1) else $error("heartbeat period wrong");
  chk_hb_bounded: assert property (hb_seen_q |-> hb_cnt_q < HB_HALF_CYCLES)
    else $error("heartbeat stalled");
endmodule
`default_nettype wire

// ### dv/weld_process_image_map_bench.sv
`default_nettype none
module weld_process_image_map_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [15:0] sin = 16'h0;
  logic [15:0] seam = 16'h5a5a;
  logic [15:0] o [0:11];
  logic [4:0] mo;
  logic [1:0] lo;
  logic [1:0] du;
  logic mrej;
  logic srej;
  logic rej_seen_q;
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [15:0] WV [0:10] = '{16'hff9c, 16'h0064, 16'hff9c, 16'h0064,
    16'hff9c, 16'h0fa0, 16'h09c4, 16'h0032, 16'h0064, 16'h1234, 16'h0abc};
  localparam logic [4:0] MD [0:6] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h09, 5'h18, 5'h19};
  weld_link_if link();
  weld_robot_end i_weld_robot_end (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
  weld_source_end #(.HB_HALF_CYCLES(8)) i_weld_source_end (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .link(link), .ready_i(sin[1]), .warning_i(sin[2]), .proc_active_i(sin[3]),
    .current_flow_i(sin[4]), .arc_stable_i(sin[5]), .main_current_i(sin[6]),
    .touch_i(sin[7]), .collision_i(sin[8]), .motion_release_i(sin[9]),
    .wire_stuck_i(sin[10]), .tip_short_i(sin[12]), .char_valid_i(sin[14]),
    .torch_gripped_i(sin[15]), .internal_seam_i(seam), .pulse_wire_o(o[0]),
    .pulse_freq_o(o[1]), .pulse_duty_o(o[2]), .arc_high_o(o[3]), .arc_low_o(o[4]),
    .resistance_o(o[5]), .inductance_o(o[6]), .stab_arc_o(o[7]), .stab_pen_o(o[8]),
    .mode_o(mo), .line_o(lo), .dual_o(du), .seam_o(o[9]), .wire_set_o(o[10]),
    .current_set_o(o[11]), .mode_reject_o(mrej), .sel_reject_o(srej));
  weld_link_properties #(.HB_HALF_CYCLES(8)) i_weld_link_properties (.clk_i(clk_i),
    .rst_i(rst_i), .mode(link.mode), .line(link.line), .dual(link.dual),
    .status(link.status));
  // free-running 50 MHz clock
  always #10 clk_i = ~clk_i;
  // any refusal pulse seen at the source end
  always @(posedge clk_i)
  begin
    if (rst_i)
      rej_seen_q <= 1'b0;
    else
      rej_seen_q <= rej_seen_q | mrej | srej;
  end
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    for (k = 0; k < 20 && ack !== 1'b1; k++)
      @(posedge clk_i);
    q = rdat;
    if (k == 20)
    begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // control word from its fields
  function automatic logic [31:0] ctl(input logic [4:0] m, input logic [1:0] l,
    input logic [1:0] d, input logic doc, input logic vs);
    return {21'h0, vs, doc, d, l, m};
  endfunction
  task automatic t_words();
    logic [31:0] q;
    for (int i = 0; i < 11; i++)
      wr(6'h04 + 6'(4 * i), {16'hffff, WV[i]});
    wr(6'h00, ctl(5'h00, 2'h0, 2'h0, 1'b1, 1'b0));
    wr(6'h3c, 32'h1);
    st(1);
    for (int i = 0; i < 11; i++)
    begin
      chk({16'h0, o[i]}, {16'h0, WV[i]});
      wb(1'b0, 6'h04 + 6'(4 * i), 32'h0, q);
      chk(q, {16'h0, WV[i]});
    end
  endtask
  task automatic t_modes();
    for (int i = 0; i < 7; i++)
    begin
      wr(6'h00, ctl(MD[i], 2'(i % 3), 2'((i + 1) % 3), 1'b1, 1'b0));
      wr(6'h3c, 32'h1);
      st(1);
      chk({27'h0, mo}, {27'h0, MD[i]});
      chk({28'h0, lo, du}, {28'h0, 2'(i % 3), 2'((i + 1) % 3)});
    end
  endtask
  task automatic t_refuse();
    logic [31:0] q;
    wr(6'h38, 32'h4);
    wr(6'h00, ctl(5'h03, 2'h0, 2'h0, 1'b0, 1'b0));
    wb(1'b0, 6'h00, 32'h0, q);
    chk(q, ctl(5'h19, 2'h0, 2'h1, 1'b1, 1'b0));
    chk({31'h0, irq}, 32'h1);
    wr(6'h34, 32'h4);
    st(1);
    chk({31'h0, irq}, 32'h0);
    wr(6'h00, ctl(5'h00, 2'h3, 2'h0, 1'b0, 1'b0));
    wr(6'h38, 32'h0);
    wb(1'b0, 6'h34, 32'h0, q);
    chk(q & 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(6'h34, 32'h4);
    wr(6'h00, ctl(5'h00, 2'h0, 2'h0, 1'b0, 1'b1));
    wr(6'h2c, 32'h0777);
    wr(6'h3c, 32'h1);
    st(1);
    chk({o[11], o[10]}, {16'h0777, WV[10]});
    chk({16'h0, o[9]}, 32'h5a5a);
    chk({31'h0, rej_seen_q}, 32'h0);
  endtask
  task automatic t_status();
    logic [31:0] q;
    for (int i = 1; i < 16; i++)
    begin
      @(posedge clk_i);
      sin <= 16'h1 << i;
      st(4);
      wb(1'b0, 6'h30, 32'h0, q);
      chk(q & 32'hfffe, {16'h0, (sin & 16'hd7fe) ^ 16'h2100});
    end
  endtask
  task automatic t_heartbeat();
    int k;
    wr(6'h34, 32'h7);
    wr(6'h38, 32'h1);
    for (k = 0; k < 40 && irq !== 1'b1; k++)
      @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    if (k == 40)
    begin
      tally_and_finish();
    end
    wr(6'h38, 32'h0);
    st(1);
    chk({31'h0, irq}, 32'h0);
  endtask
  // reset, then one task per scenario
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_words();
    t_modes();
    t_refuse();
    t_status();
    t_heartbeat();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### rtl/weld_cfg.svh
`ifndef WELD_CFG_SVH
`define WELD_CFG_SVH

// clock rate and heartbeat half period
`define CLK_KHZ 50000
`define HB_HALF_MS 500

// image word indexes (words 45..51, stabilisers, seam, command value)
`define W_PULSE_WIRE 0
`define W_PULSE_FREQ 1
`define W_PULSE_DUTY 2
`define W_ARC_HIGH 3
`define W_ARC_LOW 4
`define W_RESIST 5
`define W_INDUCT 6
`define W_STAB_ARC 7
`define W_STAB_PEN 8
`define W_SEAM 9
`define W_CMD 10

// working mode codes
`define MODE_INT_PARAM 5'h00
`define MODE_SPEC_2STEP 5'h01
`define MODE_JOB 5'h02
`define MODE_2STEP 5'h08
`define MODE_MANUAL_2STEP 5'h09
`define MODE_RL_MEASURE 5'h18
`define MODE_RL_ALIGN 5'h19
`define SEL_RESERVED 2'h3

// reset values
`define MODE_RST 5'h00
`define LINE_RST 2'h0
`define DUAL_RST 2'h0
`define STATUS_RST 16'h2100

// status bit positions (byte 0 then byte 1)
`define ST_HEARTBEAT 0
`define ST_READY 1
`define ST_WARNING 2
`define ST_PROC_ACTIVE 3
`define ST_CUR_FLOW 4
`define ST_ARC_STABLE 5
`define ST_MAIN_CUR 6
`define ST_TOUCH 7
`define ST_COLLISION_N 8
`define ST_MOTION_REL 9
`define ST_WIRE_STUCK 10
`define ST_UNUSED 11
`define ST_TIP_SHORT 12
`define ST_INT_PARAM 13
`define ST_CHAR_VALID 14
`define ST_TORCH_GRIP 15

// robot-end register indexes (byte address = index * 4)
`define R_CTRL 4'h0
`define R_WORD0 4'h1
`define R_STATUS 4'hc
`define R_IRQ_STAT 4'hd
`define R_IRQ_MASK 4'he
`define R_SEND 4'hf
`define CTRL_MODE 0
`define CTRL_LINE 5
`define CTRL_DUAL 7
`define CTRL_DOC 9
`define CTRL_VSEL 10
`define EV_HEARTBEAT 0
`define EV_STATUS 1
`define EV_REFUSED 2

`endif

// ### rtl/weld_link_if.sv
`default_nettype none
interface weld_link_if;
  logic frame;
  weld_pkg::words_t words;
  logic [4:0] mode;
  logic [1:0] line;
  logic [1:0] dual;
  logic doc;
  logic vsel;
  logic [15:0] status;

  modport robot (output frame, words, mode, line, dual, doc, vsel, input status);
  modport source (input frame, words, mode, line, dual, doc, vsel, output status);
endinterface
`default_nettype wire

// ### rtl/weld_pkg.sv
`default_nettype none
package weld_pkg;
  typedef logic [10:0][15:0] words_t;

  // the seven defined working mode codes
  function automatic logic mode_valid(input logic [4:0] m);
    return (m == 5'h00) || (m == 5'h01) || (m == 5'h02) || (m == 5'h08) ||
      (m == 5'h09) || (m == 5'h18) || (m == 5'h19);
  endfunction
endpackage
`default_nettype wire

// ### rtl/weld_robot_end.sv
`include "weld_cfg.svh"
`default_nettype none
module weld_robot_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  weld_link_if.robot link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);

  typedef struct packed {
    weld_pkg::words_t words;
    logic [4:0] mode;
    logic [1:0] line;
    logic [1:0] dual;
    logic doc;
    logic vsel;
    logic frame;
    logic [15:0] status;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  logic [3:0] idx;
  logic req;
  logic [15:0] ctrl_rd;
  logic [15:0] ctrl_new;
  logic [2:0] ev;

  assign idx = wb_adr_i[5:2];
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign ctrl_rd = {5'h0, s_q.vsel, s_q.doc, s_q.dual, s_q.line, s_q.mode};
  assign ctrl_new = merge16(ctrl_rd, wb_dat_i, wb_sel_i);

  // events: heartbeat and status changes on the returned status image, refused control writes
  always_comb
  begin
    ev = 3'h0;
    ev[`EV_HEARTBEAT] = link.status[`ST_HEARTBEAT] ^ s_q.status[`ST_HEARTBEAT];
    ev[`EV_STATUS] = |(link.status[15:1] ^ s_q.status[15:1]);
    if (req && wb_we_i && idx == `R_CTRL)
    begin
      ev[`EV_REFUSED] = !weld_pkg::mode_valid(ctrl_new[`CTRL_MODE +: 5]) ||
        ctrl_new[`CTRL_LINE +: 2] == `SEL_RESERVED ||
        ctrl_new[`CTRL_DUAL +: 2] == `SEL_RESERVED;
    end
  end

  // next-state logic: bus slave, image registers, interrupt status
  always_comb
  begin
    s_d = s_q;
    if (ce_i)
    begin
      s_d.frame = 1'b0;
      s_d.ack = req;
      s_d.status = link.status;
      if (req && wb_we_i)
      begin
        if (idx == `R_CTRL && !ev[`EV_REFUSED])
        begin
          s_d.mode = ctrl_new[`CTRL_MODE +: 5];
          s_d.line = ctrl_new[`CTRL_LINE +: 2];
          s_d.dual = ctrl_new[`CTRL_DUAL +: 2];
          s_d.doc = ctrl_new[`CTRL_DOC];
          s_d.vsel = ctrl_new[`CTRL_VSEL];
        end
        if (idx >= `R_WORD0 && idx < `R_STATUS)
        begin
          s_d.words[idx - `R_WORD0] = merge16(s_q.words[idx - `R_WORD0], wb_dat_i, wb_sel_i);
        end
        if (idx == `R_IRQ_MASK && wb_sel_i[0])
        begin
          s_d.irq_mask = wb_dat_i[2:0];
        end
        if (idx == `R_SEND && wb_sel_i[0] && wb_dat_i[0])
        begin
          s_d.frame = 1'b1;
        end
      end
      // sticky events, set wins over the write-one clear
      s_d.irq_stat = s_q.irq_stat | ev;
      if (req && wb_we_i && idx == `R_IRQ_STAT && wb_sel_i[0])
      begin
        s_d.irq_stat = (s_q.irq_stat & ~wb_dat_i[2:0]) | ev;
      end
      // read data
      s_d.rdata = 32'h0;
      if (req && !wb_we_i)
      begin
        if (idx == `R_CTRL)
        begin
          s_d.rdata[15:0] = ctrl_rd;
        end
        else if (idx < `R_STATUS)
        begin
          s_d.rdata[15:0] = s_q.words[idx - `R_WORD0];
        end
        else if (idx == `R_STATUS)
        begin
          s_d.rdata[15:0] = s_q.status;
        end
        else if (idx == `R_IRQ_STAT)
        begin
          s_d.rdata[2:0] = s_q.irq_stat;
        end
        else if (idx == `R_IRQ_MASK)
        begin
          s_d.rdata[2:0] = s_q.irq_mask;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.mode <= `MODE_RST;
      s_q.line <= `LINE_RST;
      s_q.dual <= `DUAL_RST;
      // held image matches the source's reset image, so no false status event
      s_q.status <= `STATUS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // link and bus outputs
  assign link.frame = s_q.frame;
  assign link.words = s_q.words;
  assign link.mode = s_q.mode;
  assign link.line = s_q.line;
  assign link.dual = s_q.dual;
  assign link.doc = s_q.doc;
  assign link.vsel = s_q.vsel;
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign irq_o = |(s_q.irq_stat & s_q.irq_mask);

endmodule
`default_nettype wire

// ### rtl/weld_source_end.sv
`include "weld_cfg.svh"
`default_nettype none
module weld_source_end #(
  parameter int unsigned HB_HALF_CYCLES = `HB_HALF_MS * `CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  weld_link_if.source link,
  input wire logic ready_i,
  input wire logic warning_i,
  input wire logic proc_active_i,
  input wire logic current_flow_i,
  input wire logic arc_stable_i,
  input wire logic main_current_i,
  input wire logic touch_i,
  input wire logic collision_i,
  input wire logic motion_release_i,
  input wire logic wire_stuck_i,
  input wire logic tip_short_i,
  input wire logic char_valid_i,
  input wire logic torch_gripped_i,
  input wire logic [15:0] internal_seam_i,
  output logic [15:0] pulse_wire_o,
  output logic [15:0] pulse_freq_o,
  output logic [15:0] pulse_duty_o,
  output logic [15:0] arc_high_o,
  output logic [15:0] arc_low_o,
  output logic [15:0] resistance_o,
  output logic [15:0] inductance_o,
  output logic [15:0] stab_arc_o,
  output logic [15:0] stab_pen_o,
  output logic [4:0] mode_o,
  output logic [1:0] line_o,
  output logic [1:0] dual_o,
  output logic [15:0] seam_o,
  output logic [15:0] wire_set_o,
  output logic [15:0] current_set_o,
  output logic mode_reject_o,
  output logic sel_reject_o
);

  typedef struct packed {
    logic [31:0] hb_cnt;
    logic hb;
    weld_pkg::words_t words;
    logic [4:0] mode;
    logic [1:0] line;
    logic [1:0] dual;
    logic doc;
    logic vsel;
    logic [15:0] seam;
    logic [15:0] wire_set;
    logic [15:0] cur_set;
    logic [15:0] status;
    logic mode_rej;
    logic sel_rej;
  } state_t;

  state_t s_q;
  state_t s_d;

  // heartbeat wrap point, sized to the counter
  localparam logic [31:0] HB_LAST = 32'(HB_HALF_CYCLES - 1);

  // next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.mode_rej = 1'b0;
    s_d.sel_rej = 1'b0;
    if (ce_i)
    begin
      if (s_q.hb_cnt == HB_LAST)
      begin
        s_d.hb_cnt = 32'h0;
        s_d.hb = ~s_q.hb;
      end
      else
      begin
        s_d.hb_cnt = s_q.hb_cnt + 32'h1;
      end

      // take a new image on each fieldbus frame
      if (link.frame)
      begin
        s_d.words = link.words;
        if (weld_pkg::mode_valid(link.mode))
        begin
          s_d.mode = link.mode;
        end
        else
        begin
          s_d.mode_rej = 1'b1;
        end
        if (link.line != `SEL_RESERVED)
        begin
          s_d.line = link.line;
        end
        else
        begin
          s_d.sel_rej = 1'b1;
        end
        if (link.dual != `SEL_RESERVED)
        begin
          s_d.dual = link.dual;
        end
        else
        begin
          s_d.sel_rej = 1'b1;
        end
        s_d.doc = link.doc;
        s_d.vsel = link.vsel;
      end

      s_d.seam = s_d.doc ? s_d.words[`W_SEAM] : internal_seam_i;

      if (s_d.vsel)
      begin
        s_d.cur_set = s_d.words[`W_CMD];
      end
      else
      begin
        s_d.wire_set = s_d.words[`W_CMD];
      end

      s_d.status[`ST_HEARTBEAT] = s_d.hb;
      s_d.status[`ST_READY] = ready_i;
      s_d.status[`ST_WARNING] = warning_i;
      s_d.status[`ST_PROC_ACTIVE] = proc_active_i;
      s_d.status[`ST_CUR_FLOW] = current_flow_i;
      s_d.status[`ST_ARC_STABLE] = arc_stable_i;
      s_d.status[`ST_MAIN_CUR] = main_current_i;
      s_d.status[`ST_TOUCH] = touch_i;
      s_d.status[`ST_COLLISION_N] = ~collision_i;
      s_d.status[`ST_MOTION_REL] = motion_release_i;
      s_d.status[`ST_WIRE_STUCK] = wire_stuck_i;
      s_d.status[`ST_UNUSED] = 1'b0;
      s_d.status[`ST_TIP_SHORT] = tip_short_i;
      s_d.status[`ST_INT_PARAM] = (s_d.mode == `MODE_INT_PARAM);
      s_d.status[`ST_CHAR_VALID] = char_valid_i;
      s_d.status[`ST_TORCH_GRIP] = torch_gripped_i;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.mode <= `MODE_RST;
      s_q.line <= `LINE_RST;
      s_q.dual <= `DUAL_RST;
      // collision input idle means no collision, so the low-active bit rests high
      s_q.status[`ST_COLLISION_N] <= 1'b1;
      s_q.status[`ST_INT_PARAM] <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // image words to the welding process
  assign pulse_wire_o = s_q.words[`W_PULSE_WIRE];
  assign pulse_freq_o = s_q.words[`W_PULSE_FREQ];
  assign pulse_duty_o = s_q.words[`W_PULSE_DUTY];
  assign arc_high_o = s_q.words[`W_ARC_HIGH];
  assign arc_low_o = s_q.words[`W_ARC_LOW];
  assign resistance_o = s_q.words[`W_RESIST];
  assign inductance_o = s_q.words[`W_INDUCT];
  assign stab_arc_o = s_q.words[`W_STAB_ARC];
  assign stab_pen_o = s_q.words[`W_STAB_PEN];

  // selections and derived values
  assign mode_o = s_q.mode;
  assign line_o = s_q.line;
  assign dual_o = s_q.dual;
  assign seam_o = s_q.seam;
  assign wire_set_o = s_q.wire_set;
  assign current_set_o = s_q.cur_set;
  assign mode_reject_o = s_q.mode_rej;
  assign sel_reject_o = s_q.sel_rej;

  // status image back to the robot
  assign link.status = s_q.status;

endmodule
`default_nettype wire
